// *** dv/common_clock_ram_fifo_tb_top.sv ***
// self-checking bench for the common-clock queue
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module common_clock_ram_fifo_tb_top;
    typedef struct {
        logic [11:0] addr;
        logic [31:0] data;
        logic        err;
    } reg_row_t;

    logic                     pclk;
    logic                     presetn;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [11:0]              paddr;
    logic [31:0]              pwdata;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    cq_pkg::wr_side_t         wr;
    logic                     read_enable;
    cq_pkg::rd_word_t         rd;
    cq_pkg::flags_t           flags;
    logic [cq_pkg::CNT_W-1:0] write_side_word_count;
    int                       mismatches;
    int                       n_checks;
    int                       cap;
    logic [31:0]              rdat;
    logic                     rerr;
    logic [3:0]               modes[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7};
    reg_row_t                 rows[6] = '{
        '{12'h000, 32'h0000_0000, 1'b0}, '{12'h004, 32'h0000_0005, 1'b0},
        '{12'h008, 32'h0000_0000, 1'b0}, '{12'h00C, 32'h03FC_0004, 1'b0},
        '{12'h010, 32'h03FF_0400, 1'b0}, '{12'h014, 32'h0000_0000, 1'b1}};

    cq_fifo DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wr(wr), .read_enable(read_enable),
        .rd(rd), .flags(flags), .write_side_word_count(write_side_word_count)
    );

    cq_user_model user (
        .pclk(pclk), .wr(wr), .read_enable(read_enable), .rd(rd),
        .empty(flags.empty)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic cq_pkg::rd_word_t exp_word(input logic [31:0] d);
        return {d, d[3:0]};
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // reset only with the clock running
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK(flags, 4'b1010)
        `CHK(write_side_word_count, 11'h000)
        foreach (rows[i]) begin
            apb(1'b0, rows[i].addr, 32'h0000_0000);
            `CHK(rdat, rows[i].data)
            `CHK(rerr, rows[i].err)
        end
        user.write_words(1, 32'hA5A5_0001);
        #1;
        `CHK(flags.empty, 1'b0)
        user.read_words(1, 1'b0);
        `CHK(user.got[0], exp_word(32'hA5A5_0001))
        // one word past capacity must be refused
        user.got.delete();
        user.write_words(1025, 32'h0000_1000);
        #1;
        `CHK(flags.full, 1'b1)
        `CHK(write_side_word_count, 11'h400)
        apb(1'b0, cq_pkg::OFF_STAT, 32'h0000_0000);
        `CHK(rdat, 32'h0000_001A)
        apb(1'b1, cq_pkg::OFF_STAT, 32'h0000_0010);
        user.read_words(1, 1'b0);
        `CHK(flags.full, 1'b0)
        user.read_words(1023, 1'b0);
        for (int i = 0; i < 1024; i++) `CHK(user.got[i], exp_word(32'h1000 + 32'(i)))
        apb(1'b0, cq_pkg::OFF_STAT, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0005)
        foreach (modes[i]) begin
            apb(1'b1, cq_pkg::OFF_CTRL, 32'(modes[i]));
            apb(1'b0, cq_pkg::OFF_DEPTH, 32'h0000_0000);
            cap = 1024 + $countones(modes[i][2:0]);
            `CHK(rdat, {16'(cap - 1), 16'(cap)})
        end
        apb(1'b1, cq_pkg::OFF_CTRL, 32'h0000_0009);
        user.got.delete();
        user.write_words(1026, 32'h0002_0000);
        repeat (3) @(posedge pclk);
        #1;
        `CHK(flags.full, 1'b1)
        apb(1'b0, cq_pkg::OFF_COUNT, 32'h0000_0000);
        `CHK(rdat[10:0], 11'h401)
        `CHK(write_side_word_count, 11'h401)
        user.read_words(1025, 1'b1);
        #1;
        for (int i = 0; i < 1025; i++) `CHK(user.got[i], exp_word(32'h2_0000 + 32'(i)))
        `CHK(flags.empty, 1'b1)
        // two stages ahead: fall-through with output stage
        apb(1'b1, cq_pkg::OFF_CTRL, 32'h0000_0003);
        user.got.delete();
        user.write_words(3, 32'h0003_0000);
        repeat (4) @(posedge pclk);
        user.read_words(3, 1'b1);
        for (int i = 0; i < 3; i++) `CHK(user.got[i], exp_word(32'h3_0000 + 32'(i)))
        // reset in mid-run with words queued
        user.write_words(2, 32'h0000_0077);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        `CHK(flags, 4'b1010)
        `CHK(write_side_word_count, 11'h000)
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cq_pkg::OFF_CTRL, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0000)
        summarize();
    end

    // about 6300 cycles expected; allow generous slack
    initial begin
        #(25 * 20000);
        mismatches++;
        summarize();
    end
endmodule

// *** dv/cq_user_model.sv ***
// user logic that writes and reads the queue
`timescale 1ns/1ps
module cq_user_model (
    // clock
    input  wire logic             pclk,
    // queue write side
    output cq_pkg::wr_side_t      wr,
    // queue read side
    output logic                  read_enable,
    input  wire cq_pkg::rd_word_t rd,
    input  wire logic             empty
);
    cq_pkg::rd_word_t got[$];

    initial begin
        wr          = '0;
        read_enable = 1'b0;
    end

    task automatic write_words(input int n, input logic [31:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            wr <= {1'b1, base + 32'(i), 4'(base + 32'(i))};
        end
        @(posedge pclk);
        // released lines go inverse so stale data never passes
        wr <= {1'b0, ~wr.data, ~wr.par};
    endtask

    // pop only while a word shows, then collect it
    task automatic read_words(input int n, input bit first_word_fall_through);
        int k;
        int taken;
        bit pend;
        k     = 0;
        taken = 0;
        pend  = 1'b0;
        while (k < n) begin
            @(posedge pclk);
            // standard mode: word taken at the last edge is out now
            if (pend) begin
                got.push_back(rd);
                k++;
            end
            pend = 1'b0;
            // prefetch gaps leave empty high; such edges take nothing
            if (read_enable && !empty) begin
                // fall-through shows the head before the pop edge
                if (first_word_fall_through) begin
                    got.push_back(rd);
                    k++;
                end else begin
                    pend = 1'b1;
                end
                taken++;
            end
            read_enable <= (taken < n);
        end
    endtask
endmodule

// *** src/cq_fifo.sv ***
// common-clock queue with prefetch stages and an apb control slave
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
// Operation
// - flags release within one cycle; in prefetch modes empty releases two cycles after the write edge
// - every memory word used, no spare
// - standard capacities per width and memory
// - fall-through mode adds one entry
// - pointers and flags are dedicated logic
// - small memory widths 4 to 36
// - large memory widths 4 to 72
// - write depth counts writes until full
// - read depth excludes partial words
// - depth follows stages and mode
// - ecc pipeline adds one read word
// - independent-clock depth one word smaller
// - read enable presents next word after edge
// - port a reads, port b writes
module cq_fifo (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // write side
    input  wire cq_pkg::wr_side_t           wr,
    // read side
    input  wire logic                       read_enable,
    output cq_pkg::rd_word_t                rd,
    // status
    output cq_pkg::flags_t                  flags,
    output logic      [cq_pkg::CNT_W-1:0]   write_side_word_count
);
    cq_pkg::cq_state_t          s_r;
    cq_pkg::cq_state_t          s_nxt;
    logic [cq_pkg::WORD_W-1:0]  mem_rdata;
    logic [cq_pkg::WORD_W-1:0]  out_word;
    logic [cq_pkg::CNT_W-1:0]   total;
    logic [cq_pkg::CNT_W-1:0]   cap;
    logic [1:0]                 slots;
    logic [1:0]                 ins_idx;
    logic                       first_word_fall_through;
    logic                       oreg;
    logic                       ecc;
    logic                       direct;
    logic                       full;
    logic                       empty;
    logic                       wr_ok;
    logic                       rd_ok;
    logic                       stage_room;
    logic                       prefetch;
    logic                       mem_re;
    logic                       pop;
    logic                       setup;
    logic                       access;
    logic                       mapped;
    logic                       idle;
    logic                       flush;
    logic                       stat_clr;
    logic [31:0]                stat_v;

    assign first_word_fall_through = s_r.ctrl[cq_pkg::CTRL_FIRST_WORD_FALL_THROUGH];
    assign oreg = s_r.ctrl[cq_pkg::CTRL_OREG];
    assign ecc  = s_r.ctrl[cq_pkg::CTRL_ECC];

    assign slots  = {1'b0, first_word_fall_through} + {1'b0, oreg} + {1'b0, ecc};
    assign direct = (slots == 2'h0);

    assign cap   = cq_pkg::MEM_DEPTH + {9'h000, slots};
    assign total = s_r.mcnt + {9'h000, s_r.scnt} + {10'h000, s_r.infl};

    assign full  = (total == cap);
    assign empty = direct ? (s_r.mcnt == 11'h000) : (s_r.scnt == 2'h0);

    assign wr_ok = wr.en & ~full;
    assign rd_ok = read_enable & ~empty;

    // prefetch keeps the stages topped up from memory
    assign stage_room = ({1'b0, s_r.scnt} + {2'h0, s_r.infl}) < {1'b0, slots};
    assign prefetch   = ~direct & (s_r.mcnt != 11'h000) & stage_room;
    assign mem_re     = direct ? rd_ok : prefetch;
    assign pop        = rd_ok & ~direct;
    assign ins_idx    = s_r.scnt - {1'b0, pop};

    // apb decode
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (paddr == cq_pkg::OFF_CTRL) | (paddr == cq_pkg::OFF_STAT)
                  | (paddr == cq_pkg::OFF_COUNT) | (paddr == cq_pkg::OFF_THRESH)
                  | (paddr == cq_pkg::OFF_DEPTH);
    assign idle   = (total == 11'h000);
    assign flush  = access & pwrite & (paddr == cq_pkg::OFF_CTRL)
                  & pwdata[cq_pkg::CTRL_FLUSH];
    // set beats clear: a late write-one never hides a new event
    assign stat_clr = access & pwrite & (paddr == cq_pkg::OFF_STAT);

    always_comb begin
        stat_v = 32'h0000_0000;
        stat_v[cq_pkg::STAT_EMPTY]  = empty;
        stat_v[cq_pkg::STAT_FULL]   = full;
        stat_v[cq_pkg::STAT_AEMPTY] = flags.almost_empty_flag;
        stat_v[cq_pkg::STAT_AFULL]  = flags.almost_full_flag;
        stat_v[cq_pkg::STAT_OVF]    = s_r.ovf;
        stat_v[cq_pkg::STAT_UNF]    = s_r.unf;
    end

    always_comb begin
        s_nxt = s_r;
        if (wr_ok) begin
            s_nxt.wptr = s_r.wptr + 1'b1;
        end
        if (mem_re) begin
            s_nxt.rptr = s_r.rptr + 1'b1;
        end
        s_nxt.mcnt = s_r.mcnt + {10'h000, wr_ok} - {10'h000, mem_re};
        s_nxt.infl = prefetch;
        if (pop) begin
            if (!first_word_fall_through) begin
                s_nxt.dout = s_r.stg[0];
            end
            for (int i = 0; i < cq_pkg::MAX_STAGES - 1; i++) begin
                s_nxt.stg[i] = s_r.stg[i+1];
            end
        end
        if (s_r.infl) begin
            s_nxt.stg[ins_idx] = mem_rdata;
        end
        s_nxt.scnt = s_r.scnt - {1'b0, pop} + {1'b0, s_r.infl};
        // error flags: a new event wins over a clear
        if (stat_clr) begin
            s_nxt.ovf = s_r.ovf & ~pwdata[cq_pkg::STAT_OVF];
            s_nxt.unf = s_r.unf & ~pwdata[cq_pkg::STAT_UNF];
        end
        if (wr.en & full) begin
            s_nxt.ovf = 1'b1;
        end
        if (read_enable & empty) begin
            s_nxt.unf = 1'b1;
        end
        // mode bits change only on an empty queue, else words would be stranded
        if (access & pwrite & (paddr == cq_pkg::OFF_CTRL) & idle) begin
            s_nxt.ctrl = pwdata[3:0];
        end
        if (access & pwrite & (paddr == cq_pkg::OFF_THRESH)) begin
            s_nxt.ae_thr = pwdata[cq_pkg::THR_AE_LSB +: cq_pkg::CNT_W];
            s_nxt.af_thr = pwdata[cq_pkg::THR_AF_LSB +: cq_pkg::CNT_W];
        end
        // flush drops all contents; read data registers keep their last word
        if (flush) begin
            s_nxt.wptr = '0;
            s_nxt.rptr = '0;
            s_nxt.mcnt = '0;
            s_nxt.scnt = '0;
            s_nxt.infl = 1'b0;
        end
        // read data captured in setup so it is stable for the access edge
        if (setup) begin
            case (paddr)
                cq_pkg::OFF_CTRL:   s_nxt.prdata = {28'h000_0000, s_r.ctrl};
                cq_pkg::OFF_STAT:   s_nxt.prdata = stat_v;
                cq_pkg::OFF_COUNT:  s_nxt.prdata = {5'h00, s_r.mcnt, 5'h00, total};
                cq_pkg::OFF_THRESH: s_nxt.prdata = {5'h00, s_r.af_thr, 5'h00, s_r.ae_thr};
                cq_pkg::OFF_DEPTH:  s_nxt.prdata = {5'h00, cap - cq_pkg::IC_RESERVED,
                                                    5'h00, cap};
                default:            s_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r        <= '0;
            s_r.ctrl   <= cq_pkg::CTRL_RST;
            s_r.ae_thr <= cq_pkg::AE_THR_RST;
            s_r.af_thr <= cq_pkg::AF_THR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // word stored at the write edge
    cq_mem u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .a_en    (mem_re),
        .a_addr  (s_r.rptr),
        .a_rdata (mem_rdata),
        .b_en    (wr_ok),
        .b_addr  (s_r.wptr),
        .b_wdata ({wr.data, wr.par})
    );

    // fall-through shows the head stage, standard shows the popped word
    assign out_word = direct ? mem_rdata : (first_word_fall_through ? s_r.stg[0] : s_r.dout);
    assign rd       = cq_pkg::rd_word_t'(out_word);

    assign flags.empty             = empty;
    assign flags.full              = full;
    assign flags.almost_empty_flag = (total <= s_r.ae_thr);
    assign flags.almost_full_flag  = (total >= s_r.af_thr);

    assign write_side_word_count = s_r.ctrl[cq_pkg::CTRL_KIND] ? total : s_r.mcnt;

    assign prdata  = s_r.prdata;
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    reset_clear_a: assert property (
        $rose(presetn) |-> flags.empty && !flags.full && total == 11'h000)
        else $error("queue not empty after reset");

    empty_release_a: assert property (
        direct && empty && wr_ok && !flush |=> !flags.empty)
        else $error("empty held after write in standard mode");

    full_release_a: assert property (
        full && rd_ok && !flush |=> !flags.full && total == $past(total) - 11'h001)
        else $error("full held after read");

    full_depth_a: assert property (
        direct && full |-> s_r.mcnt == cq_pkg::MEM_DEPTH && s_r.wptr == s_r.rptr)
        else $error("standard full without every word used");

    first_word_fall_through_depth_a: assert property (
        full && first_word_fall_through && !oreg && !ecc |->
            s_r.mcnt == cq_pkg::MEM_DEPTH && ({1'b0, s_r.scnt} + {2'h0, s_r.infl}) == 3'h1)
        else $error("fall-through full not one word deeper");

    ecc_depth_a: assert property (
        full && ecc && !first_word_fall_through && !oreg |-> s_r.mcnt == cq_pkg::MEM_DEPTH && total > s_r.mcnt)
        else $error("ecc pipe does not add a word");

    no_overwrite_a: assert property (
        wr_ok |-> s_r.mcnt != cq_pkg::MEM_DEPTH || mem_re)
        else $error("write into a full memory");

    count_bound_a: assert property (
        s_r.mcnt <= cq_pkg::MEM_DEPTH && s_r.scnt <= slots)
        else $error("count beyond capacity");

    ptr_track_a: assert property (
        s_r.mcnt[cq_pkg::ADDR_W-1:0] == s_r.wptr - s_r.rptr)
        else $error("pointers disagree with count");

    first_word_fall_through_order_a: assert property (
        first_word_fall_through && pop && s_r.scnt > 2'h1 && !flush |=> out_word == $past(s_r.stg[1]))
        else $error("fall-through order broken");

    overflow_flag_a: assert property (
        wr.en && full |=> s_r.ovf
            ##1 (s_r.ovf || $past(stat_clr)))
        else $error("overflow not recorded");

    underflow_flag_a: assert property (
        read_enable && empty |=> s_r.unf
            ##1 (s_r.unf || $past(stat_clr)))
        else $error("underflow not recorded");

    write_count_a: assert property (
        wr_ok && !rd_ok && !flush |=> total == $past(total) + 11'h001)
        else $error("write not counted");

    read_count_a: assert property (
        rd_ok && !wr_ok && !flush |=> total == $past(total) - 11'h001)
        else $error("read not counted");

    read_hold_a: assert property (
        direct && !mem_re |=> !direct || $stable(rd))
        else $error("read word moved without a read");

    mode_lock_a: assert property (
        !idle |=> $stable(s_r.ctrl))
        else $error("mode changed with words queued");

    fill_full_c:   cover property (wr_ok ##1 full);
    first_word_fall_through_pair_c:   cover property (first_word_fall_through && oreg && pop && s_r.scnt == 2'h2);
    first_word_fall_through_read_c:   cover property (first_word_fall_through && pop ##1 first_word_fall_through && pop);
    overflow_c:    cover property (wr.en && full);
    full_to_empty_c: cover property (full ##[1:1000] empty);
endmodule

// *** src/cq_mem.sv ***
// storage array: port a reads, port b writes, registered read data
`timescale 1ns/1ps
module cq_mem (
    // clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // read port
    input  wire logic                         a_en,
    input  wire logic [cq_pkg::ADDR_W-1:0]    a_addr,
    output logic      [cq_pkg::WORD_W-1:0]    a_rdata,
    // write port
    input  wire logic                         b_en,
    input  wire logic [cq_pkg::ADDR_W-1:0]    b_addr,
    input  wire logic [cq_pkg::WORD_W-1:0]    b_wdata
);
    logic [cq_pkg::WORD_W-1:0] mem [0:(1 << cq_pkg::ADDR_W)-1];
    cq_pkg::mem_state_t        m_r;
    cq_pkg::mem_state_t        m_nxt;

    // read-first: a read and a write of one address return the old word
    always_comb begin
        m_nxt = m_r;
        if (a_en) begin
            m_nxt.rdata = mem[a_addr];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_r <= '0;
        end else begin
            m_r <= m_nxt;
        end
    end

    always_ff @(posedge pclk) begin
        if (b_en) begin
            mem[b_addr] <= b_wdata;
        end
    end

    assign a_rdata = m_r.rdata;
endmodule

// *** src/cq_pkg.sv ***
// constants and types shared by the common-clock queue files
package cq_pkg;
    // word layout: 32 data bits and 4 parity bits
    localparam int DATA_W     = 32;
    localparam int PAR_W      = 4;
    localparam int WORD_W     = 36;
    localparam int ADDR_W     = 10;
    localparam int CNT_W      = 11;
    localparam int MAX_STAGES = 3;

    localparam logic [10:0] MEM_DEPTH   = 11'h400;
    localparam logic [10:0] IC_RESERVED = 11'h001;

    // standard-mode capacities, symmetric ports, no output register
    localparam logic [15:0] CAP_SMALL_X4  = 16'h1000;
    localparam logic [15:0] CAP_SMALL_X9  = 16'h0800;
    localparam logic [15:0] CAP_SMALL_X18 = 16'h0400;
    localparam logic [15:0] CAP_SMALL_X36 = 16'h0200;
    localparam logic [15:0] CAP_LARGE_X4  = 16'h2000;
    localparam logic [15:0] CAP_LARGE_X9  = 16'h1000;
    localparam logic [15:0] CAP_LARGE_X18 = 16'h0800;
    localparam logic [15:0] CAP_LARGE_X36 = 16'h0400;
    localparam logic [15:0] CAP_LARGE_X72 = 16'h0200;

    // independent-clock depths of the large memory at 4 bits
    localparam logic [15:0] IC_X4_LATCH_STD  = 16'h1FFF;
    localparam logic [15:0] IC_X4_LATCH_FIRST_WORD_FALL_THROUGH = 16'h2000;
    localparam logic [15:0] IC_X4_REG_STD    = 16'h2000;
    localparam logic [15:0] IC_X4_REG_FIRST_WORD_FALL_THROUGH   = 16'h2001;

    // register offsets
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_STAT   = 12'h004;
    localparam logic [11:0] OFF_COUNT  = 12'h008;
    localparam logic [11:0] OFF_THRESH = 12'h00C;
    localparam logic [11:0] OFF_DEPTH  = 12'h010;

    // field positions
    localparam int CTRL_FIRST_WORD_FALL_THROUGH   = 0;
    localparam int CTRL_OREG   = 1;
    localparam int CTRL_ECC    = 2;
    localparam int CTRL_KIND   = 3;
    localparam int CTRL_FLUSH  = 4;
    localparam int STAT_EMPTY  = 0;
    localparam int STAT_FULL   = 1;
    localparam int STAT_AEMPTY = 2;
    localparam int STAT_AFULL  = 3;
    localparam int STAT_OVF    = 4;
    localparam int STAT_UNF    = 5;
    localparam int THR_AE_LSB  = 0;
    localparam int THR_AF_LSB  = 16;
    localparam int DEPTH_IC_LSB = 16;

    // reset values
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [10:0] AE_THR_RST = 11'h004;
    localparam logic [10:0] AF_THR_RST = 11'h3FC;

    typedef struct packed {
        logic              en;
        logic [DATA_W-1:0] data;
        logic [PAR_W-1:0]  par;
    } wr_side_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [PAR_W-1:0]  par;
    } rd_word_t;

    typedef struct packed {
        logic empty;
        logic full;
        logic almost_empty_flag;
        logic almost_full_flag;
    } flags_t;

    typedef struct packed {
        logic [ADDR_W-1:0]                  wptr;
        logic [ADDR_W-1:0]                  rptr;
        logic [CNT_W-1:0]                   mcnt;
        logic [1:0]                         scnt;
        logic                               infl;
        logic [MAX_STAGES-1:0][WORD_W-1:0]  stg;
        logic [WORD_W-1:0]                  dout;
        logic [3:0]                         ctrl;
        logic [CNT_W-1:0]                   ae_thr;
        logic [CNT_W-1:0]                   af_thr;
        logic                               ovf;
        logic                               unf;
        logic [31:0]                        prdata;
    } cq_state_t;

    typedef struct packed {
        logic [WORD_W-1:0] rdata;
    } mem_state_t;
endpackage
